/* verilog/iebank_defines.vh */
// Register offsets, implemented-bit masks and field layouts of the enable bank
`ifndef IEBANK_DEFINES_VH
`define IEBANK_DEFINES_VH

// Register byte offsets on the APB
`define IEB_OFF_EN1     12'h000
`define IEB_OFF_EN2     12'h004
`define IEB_OFF_EN3     12'h008
`define IEB_OFF_FLAG1   12'h00C
`define IEB_OFF_FLAG2   12'h010
`define IEB_OFF_FLAG3   12'h014
`define IEB_OFF_PRIO_LO 12'h018
`define IEB_OFF_PRIO_HI 12'h01C
`define IEB_OFF_ISTAT   12'h020
`define IEB_OFF_IMASK   12'h024

// Implemented bits of each 16-bit bank
`define IEB_MASK1       16'hFEDF
`define IEB_MASK2       16'h3FE3
`define IEB_MASK3       16'h4066

// Reset values
`define IEB_RST16       16'h0000
`define IEB_RST32       32'h00000000

// Source counts and widths
`define IEB_NSRC        48
`define IEB_PRIO_W      3
`define IEB_PRIO_OFF    3'h0
`define IEB_PRIO_RST    3'h4

// Status bits: bank 1..3 received a new request
`define IEB_STAT_W      3

`endif

/* verilog/iebank_prio_pick.v */
// Picks the highest-priority pending source among all gated requests
`timescale 1ns/1ns
`include "iebank_defines.vh"
module iebank_prio_pick #(
    parameter NSRC = 48
) (
    input  wire [NSRC-1:0]   pend,
    input  wire [3*NSRC-1:0] prio,
    output reg               valid,
    output reg  [2:0]        level,
    output reg  [5:0]        index
);
    integer i;
    reg [2:0] p;

    // Lowest index wins among equal levels; level zero never wins
    always @* begin
        valid = 1'b0;
        level = `IEB_PRIO_OFF;
        index = 6'h00;
        p     = `IEB_PRIO_OFF;
        for (i = 0; i < NSRC; i = i + 1) begin
            p = prio[3*i +: 3];
            if (pend[i] && (p != `IEB_PRIO_OFF) && (p > level)) begin
                valid = 1'b1;
                level = p;
                index = i[5:0];
            end
        end
    end
endmodule

/* verilog/iebank_top.v */
// Interrupt enable bank with request flags, priorities and APB access
//
// Contract
// - Set enable passes request, clear blocks it
// - Enable bits read/write, zero after reset
// - Unimplemented bits read zero, store nothing
// - Bank one upper byte gate layout
// - Bank one lower byte gate layout
// - Bank two upper gate layout
// - Bank two lower gate layout
// - Bank three sparse gate layout
// - Request flags set by source, software writable
// - Three-bit priority, seven highest, zero disables
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
`include "iebank_defines.vh"
module iebank_top #(
    parameter NSRC = 48
) (
    input  wire              ref_clk,
    input  wire              nrst,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [11:0]       paddr,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output reg               pready,
    output reg               pslverr,
    input  wire [NSRC-1:0]   src_req,
    output reg  [NSRC-1:0]   gated_req,
    output reg               arb_valid,
    output reg  [2:0]        arb_level,
    output reg  [5:0]        arb_index,
    output reg               irq
);
    // Enable, flag and status storage
    reg  [15:0]        en1_q, en2_q, en3_q;
    reg  [15:0]        flag1_q, flag2_q, flag3_q;
    reg  [3*NSRC-1:0]  prio_q;
    reg  [2:0]         stat_q, imask_q;
    reg  [NSRC-1:0]    req_s1_q, req_s2_q;
    reg  [NSRC-1:0]    req_old_q;
    wire [NSRC-1:0]    req_rise;
    wire [NSRC-1:0]    en_all, flag_all, mask_all;
    wire               wr_en, rd_en;
    wire               pick_valid;
    wire [2:0]         pick_level;
    wire [5:0]         pick_index;
    reg  [31:0]        rd_d;
    reg                hit_d;
    reg  [15:0]        f1_d, f2_d, f3_d;
    reg  [2:0]         stat_d;

    // Keep only implemented bits so unused positions never hold state
    function [15:0] keep;
        input [15:0] v;
        input [15:0] m;
        begin
            keep = v & m;
        end
    endfunction

    // Priority of a range of sources, padded to a word
    function [31:0] prio_word;
        input [3*NSRC-1:0] pr;
        input              hi;
        integer k;
        begin
            prio_word = `IEB_RST32;
            for (k = 0; k < 10; k = k + 1) begin
                if ((hi ? k + 10 : k) < NSRC)
                    prio_word[3*k +: 3] = pr[3*(hi ? k + 10 : k) +: 3];
            end
        end
    endfunction

    assign mask_all = {`IEB_MASK3, `IEB_MASK2, `IEB_MASK1};
    assign en_all   = {en3_q, en2_q, en1_q};
    assign flag_all = {flag3_q, flag2_q, flag1_q};
    // Writes land on the edge that sees pready high; reads capture data
    // and clear status one edge earlier, so no event slips in between
    assign wr_en    = psel & penable & pwrite & pready;
    assign rd_en    = psel & penable & ~pwrite & ~pready;
    assign req_rise = req_s2_q & ~req_old_q & mask_all;

    // Source lines come from other logic; two flops before use
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            req_s1_q  <= {NSRC{1'b0}};
            req_s2_q  <= {NSRC{1'b0}};
            req_old_q <= {NSRC{1'b0}};
        end else begin
            req_s1_q  <= src_req;
            req_s2_q  <= req_s1_q;
            req_old_q <= req_s2_q;
        end
    end

    // Flag next state: source set wins over a software clear
    always @* begin
        f1_d = flag1_q;
        f2_d = flag2_q;
        f3_d = flag3_q;
        if (wr_en && paddr == `IEB_OFF_FLAG1)
            f1_d = keep(pwdata[15:0], `IEB_MASK1);
        if (wr_en && paddr == `IEB_OFF_FLAG2)
            f2_d = keep(pwdata[15:0], `IEB_MASK2);
        if (wr_en && paddr == `IEB_OFF_FLAG3)
            f3_d = keep(pwdata[15:0], `IEB_MASK3);
        f1_d = f1_d | req_rise[15:0];
        f2_d = f2_d | req_rise[31:16];
        f3_d = f3_d | req_rise[47:32];
    end

    // Status: one sticky bit per bank that saw a new request
    always @* begin
        stat_d = stat_q;
        if (rd_en && paddr == `IEB_OFF_ISTAT)
            stat_d = 3'h0;
        stat_d = stat_d | {|req_rise[47:32], |req_rise[31:16],
                           |req_rise[15:0]};
    end

    // Register writes; enable writes never touch the flags
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            en1_q   <= `IEB_RST16;
            en2_q   <= `IEB_RST16;
            en3_q   <= `IEB_RST16;
            flag1_q <= `IEB_RST16;
            flag2_q <= `IEB_RST16;
            flag3_q <= `IEB_RST16;
            prio_q  <= {NSRC{`IEB_PRIO_RST}};
            stat_q  <= 3'h0;
            imask_q <= 3'h0;
        end else begin
            flag1_q <= f1_d;
            flag2_q <= f2_d;
            flag3_q <= f3_d;
            stat_q  <= stat_d;
            if (wr_en) begin
                case (paddr)
                    `IEB_OFF_EN1: begin
                        // Gates 15..9 then 7,6,4..0; bit 8 and 5 empty
                        en1_q <= keep(pwdata[15:0], `IEB_MASK1);
                    end
                    `IEB_OFF_EN2: begin
                        // Gates 13..5 and 1,0
                        en2_q <= keep(pwdata[15:0], `IEB_MASK2);
                    end
                    `IEB_OFF_EN3: begin
                        // Gates 14, 6, 5, 2, 1 only
                        en3_q <= keep(pwdata[15:0], `IEB_MASK3);
                    end
                    `IEB_OFF_PRIO_LO: begin
                        prio_q[29:0] <= pwdata[29:0];
                    end
                    `IEB_OFF_PRIO_HI: begin
                        prio_q[59:30] <= pwdata[29:0];
                    end
                    `IEB_OFF_IMASK: begin
                        imask_q <= pwdata[2:0];
                    end
                    default: begin
                        imask_q <= imask_q;
                    end
                endcase
            end
        end
    end

    // Read mux; unmapped addresses answer with an error
    always @* begin
        rd_d  = `IEB_RST32;
        hit_d = 1'b1;
        case (paddr)
            `IEB_OFF_EN1:     rd_d[15:0] = en1_q;
            `IEB_OFF_EN2:     rd_d[15:0] = en2_q;
            `IEB_OFF_EN3:     rd_d[15:0] = en3_q;
            `IEB_OFF_FLAG1:   rd_d[15:0] = flag1_q;
            `IEB_OFF_FLAG2:   rd_d[15:0] = flag2_q;
            `IEB_OFF_FLAG3:   rd_d[15:0] = flag3_q;
            `IEB_OFF_PRIO_LO: rd_d = prio_word(prio_q, 1'b0);
            `IEB_OFF_PRIO_HI: rd_d = prio_word(prio_q, 1'b1);
            `IEB_OFF_ISTAT:   rd_d[2:0] = stat_q;
            `IEB_OFF_IMASK:   rd_d[2:0] = imask_q;
            default:          hit_d = 1'b0;
        endcase
    end

    // One wait state: pready rises in the second access cycle
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `IEB_RST32;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~hit_d;
            prdata  <= (rd_en & ~pready) ? rd_d : `IEB_RST32;
        end
    end

    iebank_prio_pick #(
        .NSRC (NSRC)
    ) u_pick (
        .pend  (gated_req),
        .prio  (prio_q),
        .valid (pick_valid),
        .level (pick_level),
        .index (pick_index)
    );

    // Gate flags with enables; all outputs registered
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            gated_req <= {NSRC{1'b0}};
            arb_valid <= 1'b0;
            arb_level <= `IEB_PRIO_OFF;
            arb_index <= 6'h00;
            irq       <= 1'b0;
        end else begin
            gated_req <= flag_all & en_all;
            arb_valid <= pick_valid;
            arb_level <= pick_level;
            arb_index <= pick_index;
            irq       <= |(stat_q & imask_q);
        end
    end
endmodule

/* dv/ieb_assertions.sv */
// Port-level assertions for the interrupt enable bank
`timescale 1ns/1ns
`include "iebank_defines.vh"
module ieb_chk #(
    parameter NSRC = 48
) (
    input wire            ref_clk,
    input wire            nrst,
    input wire            psel,
    input wire            penable,
    input wire            pwrite,
    input wire [11:0]     paddr,
    input wire [31:0]     pwdata,
    input wire [31:0]     prdata,
    input wire            pready,
    input wire            pslverr,
    input wire [NSRC-1:0] src_req,
    input wire [NSRC-1:0] gated_req,
    input wire            arb_valid,
    input wire [2:0]      arb_level,
    input wire [5:0]      arb_index,
    input wire            irq
);
    reg [NSRC-1:0] gated_q;
    // Last cycle's gated requests, so the arbiter's pick can be judged
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            gated_q <= {NSRC{1'b0}};
        end else begin
            gated_q <= gated_req;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    chk_ready_next:
        assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    chk_ready_pulse:
        assert property (pready |=> !pready) else $error("pready held");
    chk_gate_layout:
        assert property ((gated_req & ~{`IEB_MASK3, `IEB_MASK2,
            `IEB_MASK1}) == 48'h000000000000) else $error("bad gate bit");
    chk_read_unimpl:
        assert property (pready && !pwrite && paddr < 12'h00C |->
            (prdata & ~{16'h0000, paddr == `IEB_OFF_EN1 ? `IEB_MASK1 :
            paddr == `IEB_OFF_EN2 ? `IEB_MASK2 : `IEB_MASK3}) == 32'h0)
        else $error("unimplemented bit read back");
    chk_gate_cleared:
        assert property (pready && psel && pwrite &&
            paddr == `IEB_OFF_EN1 |-> ##2
            (gated_req[15:0] & ~$past(pwdata[15:0], 2)) == 16'h0000)
        else $error("disabled source still forwarded");
    chk_arb_pick:
        assert property (arb_valid |-> gated_q[arb_index] && arb_level != 3'h0)
        else $error("arbiter picked a blocked source");
    chk_reset_clear:
        assert property (!$past(nrst) |-> gated_req == 48'h0 && !irq)
        else $error("state not clear after reset");
    chk_irq_drop:
        assert property ($fell(irq) |-> $past(pready) || $past(pready, 2))
        else $error("irq fell without an access");
    cover property (arb_valid && arb_level == 3'h7);
    cover property ($rose(irq));
    cover property (pready && pslverr);
endmodule
bind iebank_top ieb_chk #(.NSRC(NSRC)) u_chk (.ref_clk(ref_clk),
    .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_req(src_req), .gated_req(gated_req),
    .arb_valid(arb_valid), .arb_level(arb_level), .arb_index(arb_index),
    .irq(irq));

/* dv/interrupt_enable_bank_tb.sv */
// Self-checking bench for the interrupt enable bank
`timescale 1ns/1ns
`include "iebank_defines.vh"
module interrupt_enable_bank_tb;
    reg         ref_clk = 1'b0;
    reg         nrst = 1'b0;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h00000000;
    reg  [47:0] src_req = 48'h000000000000;
    wire [31:0] prdata;
    wire        pready;
    wire        pslverr;
    wire [47:0] gated_req;
    wire        arb_valid;
    wire [2:0]  arb_level;
    wire [5:0]  arb_index;
    wire        irq;
    reg  [31:0] rd;
    reg         err;
    reg  [15:0] masks [0:2];
    integer     n_fail = 0;
    integer     samples_checked = 0;
    integer     i;
    always #25 ref_clk = ~ref_clk;
    iebank_top u_dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_req(src_req), .gated_req(gated_req), .arb_valid(arb_valid),
        .arb_level(arb_level), .arb_index(arb_index), .irq(irq));
    // Compare and count; unknowns never match
    task check(input reg [47:0] seen, input reg [47:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("Error at %0t seen %h exp %h", $time, seen, exp);
            end
        end
    endtask
    // One APB transfer; an idle edge first keeps psel from toggling twice
    task apb(input reg wr, input reg [11:0] a, input reg [31:0] d);
        integer n;
        begin
            @(posedge ref_clk);
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge ref_clk);
            penable <= 1'b1;
            n = 0;
            do begin
                @(posedge ref_clk);
                n = n + 1;
            end while (pready !== 1'b1 && n < 20);
            if (n >= 20) n_fail = n_fail + 1;
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task rchk(input reg [11:0] a, input reg [31:0] exp);
        begin
            apb(1'b0, a, 32'h00000000);
            check({16'h0000, rd}, {16'h0000, exp});
        end
    endtask
    task end_sim;
        begin
            $display("checked %0d mismatches %0d", samples_checked, n_fail);
            if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask
    // Watchdog well beyond the roughly 150 cycles the tests need
    initial begin
        #200000;
        n_fail = n_fail + 1;
        end_sim;
    end
    initial begin
        masks[0] = `IEB_MASK1;
        masks[1] = `IEB_MASK2;
        masks[2] = `IEB_MASK3;
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        // Each bank: reset value, all-ones write, then clear again
        for (i = 0; i < 3; i = i + 1) begin
            rchk({i[9:0], 2'b00}, 32'h00000000);
            apb(1'b1, {i[9:0], 2'b00}, 32'hFFFFFFFF);
            rchk({i[9:0], 2'b00}, {16'h0000, masks[i]});
            apb(1'b1, {i[9:0], 2'b00}, 32'h00000000);
            rchk({i[9:0], 2'b00}, 32'h00000000);
        end
        // Bit 8 has no gate, so its request must leave no trace
        apb(1'b1, `IEB_OFF_EN1, 32'h0000FFFF);
        src_req <= 48'h000000000300;
        repeat (6) @(posedge ref_clk);
        check(gated_req, 48'h000000000200);
        rchk(`IEB_OFF_FLAG1, 32'h00000200);
        apb(1'b1, `IEB_OFF_EN1, 32'h00000000);
        repeat (2) @(posedge ref_clk);
        check(gated_req, 48'h000000000000);
        rchk(`IEB_OFF_FLAG1, 32'h00000200);
        // Priority 7 on source 9, then priority 0 silences it
        apb(1'b1, `IEB_OFF_EN1, 32'h00000200);
        apb(1'b1, `IEB_OFF_PRIO_LO, 32'h38000000);
        repeat (3) @(posedge ref_clk);
        check({38'h0, arb_valid, arb_level, arb_index}, 48'h3C9);
        apb(1'b1, `IEB_OFF_PRIO_LO, 32'h00000000);
        repeat (3) @(posedge ref_clk);
        check({47'h0, arb_valid}, 48'h0);
        // Interrupt: masked, unmasked, then cleared by a status read
        check({47'h0, irq}, 48'h0);
        apb(1'b1, `IEB_OFF_IMASK, 32'h00000001);
        repeat (2) @(posedge ref_clk);
        check({47'h0, irq}, 48'h1);
        rchk(`IEB_OFF_ISTAT, 32'h00000001);
        repeat (2) @(posedge ref_clk);
        check({47'h0, irq}, 48'h0);
        // Software clears the flag, and the gated request goes with it
        apb(1'b1, `IEB_OFF_FLAG1, 32'h00000000);
        repeat (2) @(posedge ref_clk);
        check(gated_req, 48'h000000000000);
        // Sources 37 and 38, bank three bits 5 and 6, reach bank three
        apb(1'b1, `IEB_OFF_EN3, 32'h00000060);
        src_req <= src_req | 48'h006000000000;
        repeat (6) @(posedge ref_clk);
        check(gated_req, 48'h006000000000);
        rchk(`IEB_OFF_FLAG3, 32'h00000060);
        rchk(12'h028, 32'h00000000);
        check({47'h0, err}, 48'h1);
        end_sim;
    end
endmodule
